// ==== traffic_pkg.sv ====
package traffic_pkg;
    localparam int PRE_BYTES = 8;
    localparam int DA_BYTES = 6;
    localparam int ADDR_BYTES = 12;
    localparam int VLAN_BYTES = 4;
    localparam int TL_BYTES = 2;
    localparam int BASE_HDR = 14;
    localparam logic [15:0] MIN_SIZE_DEF = 16'h0040;
    localparam logic [15:0] MAX_SIZE_DEF = 16'h05dc;
    localparam logic [63:0] PRE_DEF = 64'h5555_5555_5555_55d5;
    // address and tag defaults are arbitrary values
    localparam logic [47:0] DA_DEF = 48'h0200_0000_0001;
    localparam logic [47:0] SA_DEF = 48'h0200_0000_0002;
    localparam logic [31:0] VLAN_DEF = 32'h8100_0001;
    localparam logic [7:0] IFG_CYCLES = 8'h0c;
    localparam logic [7:0] THROTTLE_PERIOD = 8'h3f;
    localparam int CTL_W = 7;
    localparam int CTL_GEN = 0;
    localparam int CTL_SWAP = 1;
    localparam int CTL_CHECK = 2;
    localparam int CTL_ERR = 3;
    localparam int CTL_PRE = 4;
    localparam int CTL_VLAN = 5;
    localparam int CTL_CLR = 6;
    typedef enum logic [0:0] {G_IDLE, G_SEND} gen_state_t;
    typedef enum logic [1:0] {C_HUNT, C_CAPTURE, C_CHECK} chk_state_t;
    typedef enum logic [1:0] {S_IDLE, S_FILL, S_SEND, S_PASS} swap_state_t;
endpackage

// ==== stream_if.sv ====
`timescale 1ns/10ps
`default_nettype none
interface stream_if;
    logic [7:0] tdata;
    logic tvalid;
    logic tlast;
    logic tready;
    modport src (output tdata, output tvalid, output tlast, input tready);
    modport snk (input tdata, input tvalid, input tlast, output tready);
endinterface
`default_nettype wire

// ==== addr_swap.sv ====
`timescale 1ns/10ps
`default_nettype none
module addr_swap (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic enable_in,
    stream_if.snk in_s,
    stream_if.src out_s
);
    typedef struct packed {
        traffic_pkg::swap_state_t st;
        logic [11:0][7:0] hold;
        logic [3:0] cnt;
        logic [3:0] len;
        logic short_f;
    } swap_reg_t;

    swap_reg_t r;
    swap_reg_t n;
    logic [3:0] rd;

    always_comb begin
        n = r;
        rd = r.cnt;
        in_s.tready = 1'b0;
        out_s.tvalid = 1'b0;
        out_s.tdata = in_s.tdata;
        out_s.tlast = in_s.tlast;
        unique case (r.st)
            traffic_pkg::S_IDLE, traffic_pkg::S_FILL: begin
                if (r.st == traffic_pkg::S_IDLE && !enable_in) begin
                    // bypass: fields pass untouched
                    in_s.tready = out_s.tready;
                    out_s.tvalid = in_s.tvalid;
                    if (in_s.tvalid && out_s.tready && !in_s.tlast) begin
                        n.st = traffic_pkg::S_PASS;
                    end
                end else begin
                    // collect both address fields before sending
                    in_s.tready = 1'b1;
                    if (in_s.tvalid) begin
                        n.hold[r.cnt] = in_s.tdata;
                        n.cnt = r.cnt + 4'h1;
                        n.st = traffic_pkg::S_FILL;
                        if (in_s.tlast || r.cnt == 4'(traffic_pkg::ADDR_BYTES - 1)) begin
                            n.st = traffic_pkg::S_SEND;
                            n.len = r.cnt + 4'h1;
                            n.short_f = in_s.tlast;
                            n.cnt = 4'h0;
                        end
                    end
                end
            end
            traffic_pkg::S_SEND: begin
                if (r.len == 4'(traffic_pkg::ADDR_BYTES)) begin
                    rd = (r.cnt < 4'(traffic_pkg::DA_BYTES)) ? r.cnt + 4'(traffic_pkg::DA_BYTES)
                        : r.cnt - 4'(traffic_pkg::DA_BYTES);
                end
                out_s.tvalid = 1'b1;
                out_s.tdata = r.hold[rd];
                out_s.tlast = r.short_f && (r.cnt == r.len - 4'h1);
                if (out_s.tready) begin
                    n.cnt = r.cnt + 4'h1;
                    if (r.cnt == r.len - 4'h1) begin
                        n.cnt = 4'h0;
                        n.st = r.short_f ? traffic_pkg::S_IDLE : traffic_pkg::S_PASS;
                    end
                end
            end
            traffic_pkg::S_PASS: begin
                in_s.tready = out_s.tready;
                out_s.tvalid = in_s.tvalid;
                if (in_s.tvalid && out_s.tready && in_s.tlast) begin
                    n.st = traffic_pkg::S_IDLE;
                end
            end
        endcase
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
        end else if (ce_in) begin
            r <= n;
        end
    end
endmodule
`default_nettype wire

// ==== traffic_gen_check.sv ====
`timescale 1ns/10ps
`default_nettype none
module traffic_gen_check #(
    parameter logic [15:0] MIN_SIZE = traffic_pkg::MIN_SIZE_DEF,
    parameter logic [15:0] MAX_SIZE = traffic_pkg::MAX_SIZE_DEF,
    parameter logic [47:0] DA = traffic_pkg::DA_DEF,
    parameter logic [47:0] SA = traffic_pkg::SA_DEF,
    parameter logic [63:0] PRE = traffic_pkg::PRE_DEF,
    parameter logic [31:0] VLAN = traffic_pkg::VLAN_DEF
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic ce_in,
    input wire logic gen_enable_in,
    input wire logic swap_enable_in,
    input wire logic check_enable_in,
    input wire logic insert_error_in,
    input wire logic preamble_enable_in,
    input wire logic vlan_enable_in,
    input wire logic clear_mismatch_in,
    input wire logic [7:0] rx_tdata_in,
    input wire logic rx_tvalid_in,
    input wire logic rx_tlast_in,
    output logic rx_tready_out,
    output logic [7:0] tx_tdata_out,
    output logic tx_tvalid_out,
    output logic tx_tlast_out,
    input wire logic tx_tready_in,
    output logic gen_activity_out,
    output logic check_activity_out,
    output logic mismatch_out,
    output logic byte_error_out
);
    generate
        if (MAX_SIZE < MIN_SIZE ||
            MIN_SIZE <= 16'(traffic_pkg::BASE_HDR + traffic_pkg::VLAN_BYTES)) begin : g_bad
            $error("frame size range not supported");
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////////
    // state

    typedef struct packed {
        logic [6:0] s1;
        logic [6:0] s2;
        logic [6:0] s3;
        logic [6:0] ctl;
        logic err_prev;
        logic mode_gen;
        logic rx_in_frame;
        logic loop_drop;
        logic sw_in_frame;
        logic rx_ready;
        logic [1:0][8:0] q;
        logic q_head;
        logic [1:0] q_cnt;
        traffic_pkg::gen_state_t g_st;
        logic [15:0] g_pos;
        logic [15:0] g_size;
        logic g_pre;
        logic g_vlan;
        logic g_corrupt;
        logic g_err_pend;
        logic [7:0] g_gap;
        logic [7:0] g_thr;
        logic g_act;
        traffic_pkg::chk_state_t c_st;
        logic [15:0] c_pos;
        logic [15:0] c_size;
        logic [15:0] c_tl;
        logic c_act;
        logic mismatch;
        logic byte_err;
        logic tx_v;
        logic [7:0] tx_d;
        logic tx_l;
    } state_t;

    state_t r;
    state_t n;

    ////////////////////////////////////////////////////////////////////////////////
    // frame pattern

    // returns {address flag, other address byte, expected byte}
    function automatic logic [16:0] byte_at(
        input logic [15:0] pos,
        input logic [15:0] size,
        input logic pre,
        input logic vlan
    );
        logic [15:0] p0;
        logic [15:0] pv;
        logic [15:0] pt;
        logic [15:0] k;
        logic [15:0] tl;
        logic [16:0] res;
        p0 = pre ? 16'(traffic_pkg::PRE_BYTES) : 16'h0000;
        pv = p0 + 16'(traffic_pkg::ADDR_BYTES) + (vlan ? 16'(traffic_pkg::VLAN_BYTES) : 16'h0000);
        pt = pv + 16'(traffic_pkg::TL_BYTES);
        tl = size - 16'(traffic_pkg::BASE_HDR)
            - (vlan ? 16'(traffic_pkg::VLAN_BYTES) : 16'h0000);
        res = '0;
        if (pos < p0) begin
            res[7:0] = 8'(PRE >> (16'h0008 * (16'h0007 - pos)));
        end else if (pos < p0 + 16'(traffic_pkg::DA_BYTES)) begin
            k = pos - p0;
            res[7:0] = 8'(DA >> (16'h0008 * (16'h0005 - k)));
            res[15:8] = 8'(SA >> (16'h0008 * (16'h0005 - k)));
            res[16] = 1'b1;
        end else if (pos < p0 + 16'(traffic_pkg::ADDR_BYTES)) begin
            k = pos - p0 - 16'(traffic_pkg::DA_BYTES);
            res[7:0] = 8'(SA >> (16'h0008 * (16'h0005 - k)));
            res[15:8] = 8'(DA >> (16'h0008 * (16'h0005 - k)));
            res[16] = 1'b1;
        end else if (pos < pv) begin
            k = pos - p0 - 16'(traffic_pkg::ADDR_BYTES);
            res[7:0] = 8'(VLAN >> (16'h0008 * (16'h0003 - k)));
        end else if (pos == pv) begin
            res[7:0] = tl[15:8];
        end else if (pos < pt) begin
            res[7:0] = tl[7:0];
        end else begin
            res[7:0] = tl[7:0] - 8'(pos - pt);
        end
        return res;
    endfunction

    function automatic logic [15:0] step(input logic [15:0] s);
        return (s >= MAX_SIZE) ? MIN_SIZE : s + 16'h0001;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // datapath helpers

    stream_if sw_in ();
    stream_if sw_out ();

    logic [6:0] agree;
    logic rx_beat;
    logic [16:0] gb;
    logic [16:0] cb;
    logic [15:0] g_total;
    logic [15:0] c_total;
    logic [15:0] tl_pos;
    logic g_last;
    logic g_valid;
    logic [7:0] g_data;
    logic c_last;
    logic c_err;

    assign agree = ~(r.s2 ^ r.s3);
    assign rx_beat = rx_tvalid_in & r.rx_ready;
    assign gb = byte_at(r.g_pos, r.g_size, r.g_pre, r.g_vlan);
    assign cb = byte_at(r.c_pos, r.c_size, r.ctl[traffic_pkg::CTL_PRE],
                        r.ctl[traffic_pkg::CTL_VLAN]);
    assign g_total = r.g_size + (r.g_pre ? 16'(traffic_pkg::PRE_BYTES) : 16'h0000);
    assign c_total = r.c_size
        + (r.ctl[traffic_pkg::CTL_PRE] ? 16'(traffic_pkg::PRE_BYTES) : 16'h0000);
    assign tl_pos = (r.ctl[traffic_pkg::CTL_PRE] ? 16'(traffic_pkg::PRE_BYTES) : 16'h0000)
        + 16'(traffic_pkg::ADDR_BYTES)
        + (r.ctl[traffic_pkg::CTL_VLAN] ? 16'(traffic_pkg::VLAN_BYTES) : 16'h0000);
    assign g_last = (r.g_pos == g_total - 16'h0001);
    // one idle cycle in every throttle period
    assign g_valid = (r.g_st == traffic_pkg::G_SEND)
        && (r.g_thr != traffic_pkg::THROTTLE_PERIOD);
    assign g_data = gb[7:0] ^ ((r.g_corrupt && g_last) ? 8'hff : 8'h00);
    assign c_last = (r.c_pos == c_total - 16'h0001);
    // either address value is accepted in either address position
    assign c_err = ((rx_tdata_in != cb[7:0]) && !(cb[16] && rx_tdata_in == cb[15:8]))
        || (rx_tlast_in != c_last);

    // source select into the exchanger
    assign sw_in.tvalid = r.mode_gen ? g_valid : (r.q_cnt != 2'h0);
    assign sw_in.tdata = r.mode_gen ? g_data : r.q[r.q_head][7:0];
    assign sw_in.tlast = r.mode_gen ? g_last : r.q[r.q_head][8];
    assign sw_out.tready = !r.tx_v || tx_tready_in;

    addr_swap u_swap (
        .clk_in(clk_in),
        .rst_in(rst_in),
        .ce_in(ce_in),
        .enable_in(r.ctl[traffic_pkg::CTL_SWAP]),
        .in_s(sw_in),
        .out_s(sw_out)
    );

    ////////////////////////////////////////////////////////////////////////////////
    // next state

    logic enq;
    logic drain;
    logic g_take;

    always_comb begin
        n = r;
        n.byte_err = 1'b0;
        // control pins: three stages, accept when last two agree
        n.s1 = {clear_mismatch_in, vlan_enable_in, preamble_enable_in, insert_error_in,
                check_enable_in, swap_enable_in, gen_enable_in};
        n.s2 = r.s1;
        n.s3 = r.s2;
        n.ctl = (r.ctl & ~agree) | (r.s3 & agree);
        n.err_prev = r.ctl[traffic_pkg::CTL_ERR];

        // receive framing and loopback queue
        if (rx_beat) begin
            n.rx_in_frame = !rx_tlast_in;
        end
        enq = rx_beat && !r.mode_gen && !r.loop_drop;
        drain = !r.mode_gen && (r.q_cnt != 2'h0) && sw_in.tready;
        if (rx_beat && r.loop_drop && rx_tlast_in) begin
            n.loop_drop = 1'b0;
        end
        if (enq) begin
            n.q[r.q_head ^ r.q_cnt[0]] = {rx_tlast_in, rx_tdata_in};
        end
        if (drain) begin
            n.q_head = !r.q_head;
        end
        n.q_cnt = r.q_cnt + {1'b0, enq} - {1'b0, drain};
        if (sw_in.tvalid && sw_in.tready) begin
            n.sw_in_frame = !sw_in.tlast;
        end

        // generator
        g_take = r.mode_gen && g_valid && sw_in.tready;
        unique case (r.g_st)
            traffic_pkg::G_IDLE: begin
                if (!r.mode_gen) begin
                    n.g_size = MIN_SIZE;
                end
                if (r.g_gap != 8'h00) begin
                    n.g_gap = r.g_gap - 8'h01;
                end else if (r.mode_gen && r.ctl[traffic_pkg::CTL_GEN]) begin
                    n.g_st = traffic_pkg::G_SEND;
                    n.g_pos = 16'h0000;
                    n.g_thr = 8'h00;
                    n.g_pre = r.ctl[traffic_pkg::CTL_PRE];
                    n.g_vlan = r.ctl[traffic_pkg::CTL_VLAN];
                    n.g_corrupt = r.g_err_pend;
                    n.g_err_pend = 1'b0;
                end
            end
            traffic_pkg::G_SEND: begin
                n.g_thr = (r.g_thr == traffic_pkg::THROTTLE_PERIOD) ? 8'h00
                    : r.g_thr + 8'h01;
                if (g_take) begin
                    n.g_pos = r.g_pos + 16'h0001;
                    if (g_last) begin
                        n.g_st = traffic_pkg::G_IDLE;
                        n.g_gap = traffic_pkg::IFG_CYCLES;
                        n.g_act = !r.g_act;
                        n.g_size = step(r.g_size);
                    end
                end
            end
        endcase
        // request edge wins over consumption
        if (r.ctl[traffic_pkg::CTL_ERR] && !r.err_prev) begin
            n.g_err_pend = 1'b1;
        end

        // mode change only between frames
        if (!n.sw_in_frame && n.g_st == traffic_pkg::G_IDLE
            && r.mode_gen != r.ctl[traffic_pkg::CTL_GEN]) begin
            n.mode_gen = r.ctl[traffic_pkg::CTL_GEN];
            if (n.mode_gen) begin
                n.q_cnt = 2'h0;
            end else begin
                n.loop_drop = n.rx_in_frame;
            end
        end
        n.rx_ready = n.mode_gen || n.loop_drop || (n.q_cnt != 2'h2);

        // verifier
        if (r.ctl[traffic_pkg::CTL_CLR]) begin
            n.mismatch = 1'b0;
        end
        if (!r.ctl[traffic_pkg::CTL_CHECK]) begin
            n.c_st = traffic_pkg::C_HUNT;
            n.c_pos = 16'h0000;
        end else begin
            unique case (r.c_st)
                traffic_pkg::C_HUNT: begin
                    if ((rx_beat && rx_tlast_in) || (!rx_beat && !r.rx_in_frame)) begin
                        n.c_st = traffic_pkg::C_CAPTURE;
                        n.c_pos = 16'h0000;
                    end
                end
                traffic_pkg::C_CAPTURE: begin
                    if (rx_beat) begin
                        n.c_pos = r.c_pos + 16'h0001;
                        if (r.c_pos == tl_pos) begin
                            n.c_tl[15:8] = rx_tdata_in;
                        end
                        if (r.c_pos == tl_pos + 16'h0001) begin
                            n.c_tl[7:0] = rx_tdata_in;
                        end
                        if (rx_tlast_in) begin
                            n.c_st = traffic_pkg::C_CHECK;
                            n.c_pos = 16'h0000;
                            n.c_size = step(n.c_tl + 16'(traffic_pkg::BASE_HDR)
                                + (r.ctl[traffic_pkg::CTL_VLAN]
                                ? 16'(traffic_pkg::VLAN_BYTES) : 16'h0000));
                        end
                    end
                end
                traffic_pkg::C_CHECK: begin
                    if (rx_beat) begin
                        n.c_pos = r.c_pos + 16'h0001;
                        if (c_err) begin
                            n.mismatch = 1'b1;
                            n.byte_err = 1'b1;
                            n.c_pos = 16'h0000;
                            n.c_st = rx_tlast_in ? traffic_pkg::C_CAPTURE
                                : traffic_pkg::C_HUNT;
                        end else if (rx_tlast_in) begin
                            n.c_act = !r.c_act;
                            n.c_pos = 16'h0000;
                            n.c_size = step(r.c_size);
                        end
                    end
                end
                default: begin
                    n.c_st = traffic_pkg::C_HUNT;
                end
            endcase
        end

        // transmit output stage
        if (sw_out.tready) begin
            n.tx_v = sw_out.tvalid;
            n.tx_d = sw_out.tdata;
            n.tx_l = sw_out.tlast;
        end
    end

    always_ff @(posedge clk_in) begin
        if (rst_in) begin
            r <= '0;
        end else if (ce_in) begin
            r <= n;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // outputs

    assign rx_tready_out = r.rx_ready;
    assign tx_tdata_out = r.tx_d;
    assign tx_tvalid_out = r.tx_v;
    assign tx_tlast_out = r.tx_l;
    assign gen_activity_out = r.g_act;
    assign check_activity_out = r.c_act;
    assign mismatch_out = r.mismatch;
    assign byte_error_out = r.byte_err;
endmodule
`default_nettype wire

// ==== traffic_asserts.sv ====
`timescale 1ns/10ps
`default_nettype none
module traffic_asserts #(
    parameter logic [15:0] MAX_SIZE = traffic_pkg::MAX_SIZE_DEF
) (
    input wire logic clk_in,
    input wire logic rst_in,
    input wire logic gen_enable_in,
    input wire logic check_enable_in,
    input wire logic clear_mismatch_in,
    input wire logic rx_tready_out,
    input wire logic [7:0] tx_tdata_out,
    input wire logic tx_tvalid_out,
    input wire logic tx_tlast_out,
    input wire logic tx_tready_in,
    input wire logic gen_activity_out,
    input wire logic check_activity_out,
    input wire logic mismatch_out,
    input wire logic byte_error_out
);
    localparam logic [15:0] LIMIT = MAX_SIZE * 16'h0004;
    logic [3:0] clr_age_r, off_r;
    logic [15:0] on_r, idle_r;
    // saturating ages of clear, verifier off, generator on and off
    always_ff @(posedge clk_in) begin
        clr_age_r <= (rst_in || clear_mismatch_in) ? 4'h0 : clr_age_r + 4'(clr_age_r != 4'hf);
        off_r <= (rst_in || check_enable_in) ? 4'h0 : off_r + 4'(off_r != 4'hf);
        on_r <= gen_enable_in ? on_r + 16'(on_r != 16'hffff) : 16'h0000;
        idle_r <= (rst_in || gen_enable_in) ? 16'h0000 : idle_r + 16'(idle_r != 16'hffff);
    end
    default clocking cb @(posedge clk_in); endclocking
    default disable iff (rst_in);
    chk_tx_beat_hold: assert property (tx_tvalid_out && !tx_tready_in |=> tx_tvalid_out
        && $stable({tx_tdata_out, tx_tlast_out})) else $error("tx beat dropped");
    chk_clear_only: assert property ($fell(mismatch_out) |-> clr_age_r < 4'h8)
        else $error("mismatch fell without clear");
    chk_err_flags: assert property (byte_error_out |-> ##[0:1] mismatch_out)
        else $error("byte error not latched");
    chk_flag_cause: assert property ($rose(mismatch_out) |-> byte_error_out
        || $past(byte_error_out)) else $error("mismatch rose without byte error");
    chk_off_quiet: assert property (off_r > 4'h7 |-> !byte_error_out
        && !$rose(mismatch_out)) else $error("verifier off but flagged");
    chk_gen_drains: assert property (on_r > 16'h0040 |-> rx_tready_out)
        else $error("rx not drained in generator mode");
    chk_gen_still: assert property (idle_r > LIMIT |-> $stable(gen_activity_out))
        else $error("tx activity moved while generator off");
    chk_rx_act_on: assert property ($changed(check_activity_out) |-> off_r < 4'h8)
        else $error("rx activity moved while verifier off");
    cov_gen_frame: cover property ($changed(gen_activity_out));
    cov_flag_set: cover property ($rose(mismatch_out));
    cov_rx_ok: cover property ($changed(check_activity_out));
endmodule
bind traffic_gen_check traffic_asserts #(.MAX_SIZE(MAX_SIZE)) u_chk (.clk_in, .rst_in,
    .gen_enable_in, .check_enable_in, .clear_mismatch_in, .rx_tready_out, .tx_tdata_out,
    .tx_tvalid_out, .tx_tlast_out, .tx_tready_in, .gen_activity_out, .check_activity_out,
    .mismatch_out, .byte_error_out);
`default_nettype wire

// ==== fifo_model.sv ====
`timescale 1ns/10ps
`default_nettype none
module fifo_model (
    input wire logic clk_in,
    input wire logic loop_in,
    input wire logic [1:0] pace_in,
    input wire logic rx_tready_in,
    output logic [7:0] rx_tdata_out,
    output logic rx_tvalid_out,
    output logic rx_tlast_out,
    input wire logic [7:0] tx_tdata_in,
    input wire logic tx_tvalid_in,
    input wire logic tx_tlast_in,
    output logic tx_tready_out
);
    logic [8:0] rx_q[$];
    logic [8:0] tx_q[$];
    int taken = 0;
    int first_at = 0;
    int cyc = 0;
    logic took;
    initial begin
        {rx_tdata_out, rx_tvalid_out, rx_tlast_out, tx_tready_out} = 11'h000;
    end
    // take handshakes at the edge, move outputs just after it; idle data flips
    always @(posedge clk_in) begin
        took = rx_tvalid_out && rx_tready_in;
        if (took) begin
            void'(rx_q.pop_front());
            taken++;
        end
        if (tx_tvalid_in && tx_tready_out) begin
            if (tx_q.size() == 0) first_at = taken;
            tx_q.push_back({tx_tlast_in, tx_tdata_in});
            if (loop_in) rx_q.push_back({tx_tlast_in, tx_tdata_in});
        end
        cyc++;
        #1;
        tx_tready_out = (cyc % (pace_in + 1)) == 0;
        if (!rx_tvalid_out || took) begin
            rx_tvalid_out = rx_q.size() != 0 && tx_tready_out;
            {rx_tlast_out, rx_tdata_out} = rx_tvalid_out ? rx_q[0] : {1'b0, ~rx_tdata_out};
        end
    end
endmodule
`default_nettype wire

// ==== testbench.sv ====
`timescale 1ns/10ps
`default_nettype none
module testbench;
    localparam logic [15:0] MIN_SZ = 16'h0018;
    localparam logic [15:0] MAX_SZ = 16'h001a;
    logic clk_in = 1'b0;
    logic rst_in = 1'b1;
    logic ce = 1'b1;
    logic gen_en = 1'b0, swap_en = 1'b0, chk_en = 1'b0, err = 1'b0;
    logic pre_en = 1'b0, vlan_en = 1'b0, clr = 1'b0, loop = 1'b0;
    logic [1:0] pace = 2'h1;
    logic [7:0] rx_data, tx_data;
    logic rx_valid, rx_last, rx_ready, tx_valid, tx_last, tx_ready;
    logic gen_act, chk_act, mism, byte_err, gen_q, chk_q;
    int mismatches = 0;
    int comparisons = 0;
    int gen_flips = 0;
    int chk_flips = 0;
    int err_pulses = 0;
    always #20 clk_in = ~clk_in;
    always @(posedge clk_in) begin
        if (gen_act !== gen_q) gen_flips++;
        if (chk_act !== chk_q) chk_flips++;
        if (byte_err === 1'b1) err_pulses++;
        gen_q = gen_act;
        chk_q = chk_act;
    end
    traffic_gen_check #(.MIN_SIZE(MIN_SZ), .MAX_SIZE(MAX_SZ)) dut (
        .clk_in, .rst_in, .ce_in(ce), .gen_enable_in(gen_en), .swap_enable_in(swap_en),
        .check_enable_in(chk_en), .insert_error_in(err), .preamble_enable_in(pre_en),
        .vlan_enable_in(vlan_en), .clear_mismatch_in(clr), .rx_tdata_in(rx_data),
        .rx_tvalid_in(rx_valid), .rx_tlast_in(rx_last), .rx_tready_out(rx_ready),
        .tx_tdata_out(tx_data), .tx_tvalid_out(tx_valid), .tx_tlast_out(tx_last),
        .tx_tready_in(tx_ready), .gen_activity_out(gen_act), .check_activity_out(chk_act),
        .mismatch_out(mism), .byte_error_out(byte_err));
    fifo_model u_fifo (.clk_in, .loop_in(loop), .pace_in(pace), .rx_tready_in(rx_ready),
        .rx_tdata_out(rx_data), .rx_tvalid_out(rx_valid), .rx_tlast_out(rx_last),
        .tx_tdata_in(tx_data), .tx_tvalid_in(tx_valid), .tx_tlast_in(tx_last),
        .tx_tready_out(tx_ready));
    task automatic tick(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
        comparisons++;
        if (got !== exp) begin
            mismatches++;
            $display("[FAIL] %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", comparisons, mismatches);
        if (mismatches == 0 && comparisons > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    task automatic wait_bytes(input int n);
        int k;
        k = 0;
        while (u_fifo.tx_q.size() < n && k < 4000) begin
            tick(1);
            k++;
        end
        if (k == 4000) begin
            mismatches++;
            $display("[FAIL] tx bytes expected %0d seen %0d", n, u_fifo.tx_q.size());
            tally_and_finish();
        end
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        int b, e;
        logic [15:0] sz, tl;
        logic [7:0] x;
        tick(8);
        rst_in = 1'b0;
        tick(2);
        check("tx valid after reset", 16'h0, 16'(tx_valid));
        $display("test reset done");
        for (int s = 0; s < 2; s++) begin
            swap_en = s[0];
            pace = 2'(s + 1);
            tick(8);
            u_fifo.tx_q.delete();
            u_fifo.taken = 0;
            for (int k = 0; k < 20; k++) u_fifo.rx_q.push_back({k == 19, 8'h10 + 8'(k)});
            wait_bytes(20);
            for (int k = 0; k < 20; k++) begin
                e = (s == 1 && k < 12) ? (k + 6) % 12 : k;
                check("loop byte", 16'({k == 19, 8'h10 + 8'(e)}), 16'(u_fifo.tx_q[k]));
            end
            if (s == 1) check("swap hold", 16'h1, 16'(u_fifo.first_at >= 12));
            $display("test loopback swap %0d done", s);
        end
        swap_en = 1'b0;
        pace = 2'h1;
        tick(8);
        u_fifo.tx_q.delete();
        gen_flips = 0;
        gen_en = 1'b1;
        wait_bytes(99);
        check("rx ready in generator", 16'h1, 16'(rx_ready));
        b = 0;
        for (int f = 0; f < 4; f++) begin
            sz = MIN_SZ + 16'(f % 3);
            tl = sz - 16'h000e;
            for (int j = 0; j < sz; j++) begin
                if (j < 6) x = 8'(traffic_pkg::DA_DEF >> (40 - 8 * j));
                else if (j < 12) x = 8'(traffic_pkg::SA_DEF >> (88 - 8 * j));
                else if (j < 14) x = 8'(tl >> (104 - 8 * j));
                else x = tl[7:0] - 8'(j - 14);
                check("gen byte", 16'({j == sz - 1, x}), 16'(u_fifo.tx_q[b + j]));
            end
            b += int'(sz);
        end
        check("tx activity", 16'h1, 16'(gen_flips >= 3));
        gen_en = 1'b0;
        tick(150);
        $display("test generator done");
        {pre_en, vlan_en, loop, chk_en} = 4'hf;
        pace = 2'h0;
        tick(8);
        chk_flips = 0;
        gen_en = 1'b1;
        tick(600);
        check("rx activity", 16'h1, 16'(chk_flips >= 3));
        check("clean mismatch", 16'h0, 16'(mism));
        err_pulses = 0;
        err = 1'b1;
        tick(8);
        err = 1'b0;
        tick(300);
        check("fault mismatch", 16'h1, 16'(mism));
        check("byte error pulses", 16'h1, 16'(err_pulses));
        clr = 1'b1;
        tick(8);
        clr = 1'b0;
        chk_flips = 0;
        tick(400);
        check("cleared mismatch", 16'h0, 16'(mism));
        check("resync activity", 16'h1, 16'(chk_flips >= 2));
        $display("test verifier done");
        chk_en = 1'b0;
        tick(8);
        err_pulses = 0;
        err = 1'b1;
        tick(8);
        err = 1'b0;
        tick(300);
        check("off mismatch", 16'h0, 16'(mism));
        check("off byte errors", 16'h0, 16'(err_pulses));
        $display("test verifier off done");
        {loop, gen_en} = 2'h0;
        tick(150);
        gen_flips = 0;
        ce = 1'b0;
        gen_en = 1'b1;
        tick(30);
        check("frozen tx valid", 16'h0, 16'(tx_valid));
        check("frozen activity", 16'h0, 16'(gen_flips));
        ce = 1'b1;
        tick(200);
        check("resumed activity", 16'h1, 16'(gen_flips >= 1));
        $display("test clock enable done");
        tally_and_finish();
    end
endmodule
`default_nettype wire
